/* File: rtl/seg_bus_pkg.sv */
`default_nettype none
package seg_bus_pkg;
  localparam int SEGS       = 4;
  localparam int WORD_W     = 128;
  localparam int CHAN_W     = 11;
  localparam int EMPTY_W    = 4;
  localparam int EMPTY_LOW  = 3;
  localparam int FIFO_DEPTH = 16;
  localparam int READY_HIGH = 12;
  localparam int DRAIN_DIV  = 2;

  typedef logic [WORD_W-1:0]  word_t;
  typedef logic [CHAN_W-1:0]  chan_t;
  typedef logic [EMPTY_W-1:0] empty_t;

  // One qualified segment transfer as the device keeps it.
  typedef struct packed {
    logic   first;
    logic   last;
    logic   bad;
    empty_t empty;
    chan_t  chan;
    word_t  word;
  } seg_beat_t;
endpackage
`default_nettype wire

/* File: rtl/seg_bus_if.sv */
`default_nettype none
interface seg_bus_if;
  import seg_bus_pkg::*;
  logic   tx_segment_valid [SEGS];
  logic   tx_packet_first  [SEGS];
  logic   tx_packet_last   [SEGS];
  logic   tx_packet_bad    [SEGS];
  empty_t tx_empty_bytes   [SEGS];
  word_t  tx_segment_word  [SEGS];
  chan_t  tx_channel_id    [SEGS];
  logic   tx_accept_ok;
  logic   tx_overrun_flag;

  modport device (
    input  tx_segment_valid, tx_packet_first, tx_packet_last,
           tx_packet_bad, tx_empty_bytes, tx_segment_word, tx_channel_id,
    output tx_accept_ok, tx_overrun_flag
  );
  modport source (
    output tx_segment_valid, tx_packet_first, tx_packet_last,
           tx_packet_bad, tx_empty_bytes, tx_segment_word, tx_channel_id,
    input  tx_accept_ok, tx_overrun_flag
  );
endinterface
`default_nettype wire

/* File: rtl/tx_segment_input.sv */
`default_nettype none
// Overview of operation
// - Capture segment inputs only when valid is high.
// - Source marks first transfer only on opening beat.
// - Source marks last transfer only on closing beat.
// - Error flag used only with valid and last.
// - Empty count used only with valid and last.
// - Error on last forces empty low bits zero.
// - Four independent segments, numbered zero to three.
// - 128-bit word captured whenever segment is valid, outside reset, with room in buffer.
// - 11-bit channel captured whenever segment is valid, outside reset, with room in buffer.
// - Ready follows buffer fill; source stops when low.
// - Overrun flag rises when back-pressure is ignored.
module tx_segment_input #(
  // Buffer depth in beats.
  parameter int DEPTH = seg_bus_pkg::FIFO_DEPTH,
  // Fill at or below which ready stays high.
  parameter int HIGH  = seg_bus_pkg::READY_HIGH
) (
  // System.
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // Segmented transmit bus.
  seg_bus_if.device                 bus,
  // Drain side toward the protocol engine.
  input  wire logic                 drainEn,
  output var  logic                 outValid,
  output var  seg_bus_pkg::seg_beat_t outBeat,
  output var  logic [1:0]           outSeg,
  output var  logic                 overrunSticky
);
  import seg_bus_pkg::*;

  // The block takes up to four segments a cycle from the source and
  // queues them, in lane order, for a drain side that takes at most
  // one beat a cycle. A source that keeps all four lanes busy will
  // therefore see ready fall quickly: the queue smooths bursts, it
  // does not raise the drain rate.

  // Pointer width. The fill count has one bit more, so that a full
  // buffer and an empty one are told apart without giving up a slot;
  // the depth must therefore be a power of two.
  localparam int PW = $clog2(DEPTH);

  // Qualifying a segment. The flags and the empty count only mean
  // something when the lane is valid, and the error flag and empty
  // count only on a closing beat; anything else is zeroed here so
  // that stray values from the source never leak downstream.
  function automatic seg_beat_t qualify(input logic   f,
                                        input logic   l,
                                        input logic   b,
                                        input empty_t e,
                                        input chan_t  c,
                                        input word_t  w);
    seg_beat_t r;
    r       = '0;
    r.first = f;
    r.last  = l;
    r.chan  = c;
    r.word  = w;
    if (l) begin
      r.bad   = b;
      r.empty = e;
      // An errored packet has no trustworthy byte count, so the low
      // bits are cleared; the top bit still passes as given.
      if (b) begin
        r.empty[EMPTY_LOW-1:0] = '0;
      end
    end
    return r;
  endfunction

  // True while the buffer can still take one more beat. A beat that
  // meets a full buffer is lost; only the overrun flag tells of it.
  // Every lane asks the same question, so the compare is kept here.
  function automatic logic has_room(input logic [PW:0] fill);
    return fill < (PW+1)'(DEPTH);
  endfunction

  // Ready compare against the threshold. The gap between threshold
  // and depth covers the beats that a source reacting to ready one
  // cycle late may still send, one for each segment.
  function automatic logic below_mark(input logic [PW:0] fill);
    return fill <= (PW+1)'(HIGH);
  endfunction

  // All state of the block. The beat store itself is kept apart in
  // the arrays below, since a packed struct holding every beat would
  // be copied whole on every cycle and would swamp the next-state
  // logic for no gain.
  typedef struct packed {
    // Buffer bookkeeping.
    logic [PW:0]   count;
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    // Back-pressure and overrun toward the source; sticky overrun to the drain side.
    logic          ready;
    logic          overrun;
    logic          overrunSeen;
    // Drain side toward the protocol engine.
    logic          outValid;
    seg_beat_t     outBeat;
    logic [1:0]    outSeg;
  } state_t;

  state_t s_q, s_d;

  // Buffer storage. The arrays carry no reset: a slot is only read
  // by a pop, and a pop only happens once a push has written it.
  seg_beat_t     mem    [DEPTH];
  logic [1:0]    segMem [DEPTH];

  // Write strobe and slot of each segment. They are worked out once,
  // in the next-state logic, so that the storage process and the
  // fill count can never disagree about which pushes were taken.
  logic          wrEn   [SEGS];
  logic [PW-1:0] wrAddr [SEGS];

  // Next-state logic. Segments are pushed in order 0..3 each cycle,
  // so the drain side sees them in lane order. A pop in the same
  // cycle does not make room for that cycle's pushes: keeping the
  // two apart costs one slot of headroom but keeps the compare short.
  always_comb begin
    logic [PW:0]   cnt;
    logic [PW-1:0] wp;
    logic          pop;
    cnt         = s_q.count;
    wp          = s_q.wrPtr;
    pop         = drainEn && (s_q.count != '0);
    s_d         = s_q;
    s_d.overrun = 1'b0;
    // Pushes. An idle lane leaves every one of its inputs but its valid unread.
    // Lanes are walked in a fixed order, so within one cycle lane 0
    // always lands ahead of lane 3.
    for (int i = 0; i < SEGS; i++) begin
      wrEn[i]   = 1'b0;
      wrAddr[i] = wp;
      if (bus.tx_segment_valid[i] && !rst) begin
        if (has_room(cnt)) begin
          wrEn[i] = 1'b1;
          cnt     = cnt + 1'b1;
          wp      = wp + 1'b1;
        end else begin
          // Dropped beat: the source ignored back-pressure.
          s_d.overrun = 1'b1;
        end
      end
    end
    // Pop. The oldest beat goes to the drain side and then stands
    // on the outputs until the next pop; outValid marks the cycle.
    // Asking for a beat from an empty buffer is harmless and shows
    // no outValid.
    if (pop) begin
      cnt         = cnt - 1'b1;
      s_d.rdPtr   = s_q.rdPtr + 1'b1;
      s_d.outBeat = mem[s_q.rdPtr];
      s_d.outSeg  = segMem[s_q.rdPtr];
    end
    s_d.outValid    = pop;
    s_d.count       = cnt;
    s_d.wrPtr       = wp;
    // Ready follows the fill after this cycle's pushes and pop.
    s_d.ready       = below_mark(cnt);
    // The sticky copy is set by the event and cleared by reset only.
    s_d.overrunSeen = s_q.overrunSeen | s_d.overrun;
    // Synchronous reset: empty buffer, ready low, flags clear.
    if (rst) begin
      s_d = '0;
    end
  end

  // Storage writes follow the strobes. Each taken segment is cleaned
  // by qualify on the way in, so the drain side never sees a flag or
  // an empty count that must be disregarded, and the drain logic
  // needs no knowledge of the framing rules.
  always_ff @(posedge mclk) begin
    for (int i = 0; i < SEGS; i++) begin
      if (wrEn[i]) begin
        mem[wrAddr[i]]    <= qualify(bus.tx_packet_first[i],
                                     bus.tx_packet_last[i],
                                     bus.tx_packet_bad[i],
                                     bus.tx_empty_bytes[i],
                                     bus.tx_channel_id[i],
                                     bus.tx_segment_word[i]);
        segMem[wrAddr[i]] <= 2'(i);
      end
    end
  end

  // State register. The reset lives in the next-state logic, so this
  // stays a plain flop and every output below comes straight from it.
  always_ff @(posedge mclk) begin
    s_q <= s_d;
  end

  // Outputs. Ready and the overrun pulse go back to the source on
  // the bus; the beat, its lane and the sticky overrun go to the
  // drain side. None of them passes through logic after the flops.
  assign bus.tx_accept_ok    = s_q.ready;
  assign bus.tx_overrun_flag = s_q.overrun;
  assign outValid            = s_q.outValid;
  assign outBeat             = s_q.outBeat;
  assign outSeg              = s_q.outSeg;
  assign overrunSticky       = s_q.overrunSeen;
endmodule
`default_nettype wire

/* File: rtl/tx_segment_source.sv */
`default_nettype none
// Source end: puts each user packet word whole on the one segment lane
// that reqSeg picks, one beat a cycle, and honours the device's ready.
module tx_segment_source (
  // System.
  input  wire logic                  mclk,
  input  wire logic                  rst,
  // User request.
  input  wire logic                  reqValid,
  input  wire logic [1:0]            reqSeg,
  input  wire logic                  reqFirst,
  input  wire logic                  reqLast,
  input  wire logic                  reqBad,
  input  wire seg_bus_pkg::empty_t   reqEmpty,
  input  wire seg_bus_pkg::chan_t    reqChan,
  input  wire seg_bus_pkg::word_t    reqWord,
  output var  logic                  reqTaken,
  output var  logic                  inPacket,
  // Segmented transmit bus.
  seg_bus_if.source                  bus
);
  import seg_bus_pkg::*;

  typedef struct packed {
    logic      valid;
    logic [1:0] seg;
    seg_beat_t beat;
    logic      taken;
    logic      open;
  } state_t;

  state_t s_q, s_d;

  // Take a beat only while ready is high; first only outside a packet.
  always_comb begin
    logic ok;
    ok = reqValid && bus.tx_accept_ok &&
         (reqFirst != s_q.open);
    s_d       = s_q;
    s_d.valid = 1'b0;
    s_d.taken = 1'b0;
    if (ok) begin
      s_d.valid      = 1'b1;
      s_d.taken      = 1'b1;
      s_d.seg        = reqSeg;
      s_d.beat.first = reqFirst;
      s_d.beat.last  = reqLast;
      s_d.beat.bad   = reqLast & reqBad;
      s_d.beat.empty = reqLast ? reqEmpty : '0;
      s_d.beat.chan  = reqChan;
      s_d.beat.word  = reqWord;
      s_d.open       = !reqLast;
    end
    if (rst) begin
      s_d = '0;
    end
  end

  always_ff @(posedge mclk) begin
    s_q <= s_d;
  end

  // Drive one segment lane per beat; the others stay idle.
  always_comb begin
    for (int i = 0; i < SEGS; i++) begin
      bus.tx_segment_valid[i] = s_q.valid && s_q.seg == 2'(i);
      bus.tx_packet_first[i]  = s_q.beat.first;
      bus.tx_packet_last[i]   = s_q.beat.last;
      bus.tx_packet_bad[i]    = s_q.beat.bad;
      bus.tx_empty_bytes[i]   = s_q.beat.empty;
      bus.tx_channel_id[i]    = s_q.beat.chan;
      bus.tx_segment_word[i]  = s_q.beat.word;
    end
  end

  assign reqTaken = s_q.taken;
  assign inPacket = s_q.open;
endmodule
`default_nettype wire

/* File: testbench/seg_bus_chk.sv */
`default_nettype none
module seg_bus_chk
  import seg_bus_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Watched bus lines.
  input wire logic tx_segment_valid [SEGS],
  input wire logic tx_packet_first  [SEGS],
  input wire logic tx_packet_last   [SEGS],
  input wire logic tx_accept_ok,
  input wire logic tx_overrun_flag
);
  logic [SEGS-1:0] v, f, l;
  logic            open_q, open_d;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Flatten the lanes so packet framing is seen across all of them.
  always_comb begin
    for (int i = 0; i < SEGS; i++) begin
      v[i] = tx_segment_valid[i];
      f[i] = v[i] & tx_packet_first[i];
      l[i] = v[i] & tx_packet_last[i];
    end
    open_d = (|l) ? 1'b0 : ((|f) ? 1'b1 : open_q);
  end
  // Tracks whether a packet is open on the bus.
  always_ff @(posedge mclk) begin
    open_q <= rst ? 1'b0 : open_d;
  end
  sequence s_wake; !tx_accept_ok ##[1:2] tx_accept_ok; endsequence
  property p_one; $onehot0(v); endproperty
  property p_gate; |v |-> $past(tx_accept_ok); endproperty
  property p_noovf; !tx_overrun_flag; endproperty
  property p_ovfpulse; tx_overrun_flag |=> !tx_overrun_flag; endproperty
  property p_firstout; |f |-> !open_q; endproperty
  property p_midin; (|v && !(|f)) |-> open_q; endproperty
  property p_lastin; |l |-> (open_q || |f); endproperty
  property p_wake; $fell(rst) |-> s_wake; endproperty
  a_one: assert property (p_one) else $error("two lanes");
  a_gate: assert property (p_gate) else $error("sent unready");
  a_noovf: assert property (p_noovf) else $error("overrun");
  a_ovfpulse: assert property (p_ovfpulse) else $error("ovf long");
  a_firstout: assert property (p_firstout) else $error("reopen");
  a_midin: assert property (p_midin) else $error("no first");
  a_lastin: assert property (p_lastin) else $error("stray last");
  a_wake: assert property (p_wake) else $error("ready late");
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import seg_bus_pkg::*;
  logic       mclk, rst, reqValid, reqFirst, reqLast, reqBad, drainEn;
  logic [1:0] reqSeg, outSeg;
  empty_t     reqEmpty;
  chan_t      reqChan;
  word_t      reqWord;
  logic       reqTaken, inPacket, outValid, overrunSticky, openExp;
  seg_beat_t  outBeat;
  int         miscompares, comparisons;
  seg_bus_if seg_bus_if_inst ();
  tx_segment_source tx_segment_source_inst (.mclk, .rst, .reqValid,
    .reqSeg, .reqFirst, .reqLast, .reqBad, .reqEmpty, .reqChan, .reqWord,
    .reqTaken, .inPacket, .bus(seg_bus_if_inst));
  tx_segment_input tx_segment_input_inst (.mclk, .rst,
    .bus(seg_bus_if_inst), .drainEn, .outValid, .outBeat, .outSeg,
    .overrunSticky);
  seg_bus_chk seg_bus_chk_inst (.mclk, .rst,
    .tx_segment_valid(seg_bus_if_inst.tx_segment_valid),
    .tx_packet_first(seg_bus_if_inst.tx_packet_first),
    .tx_packet_last(seg_bus_if_inst.tx_packet_last),
    .tx_accept_ok(seg_bus_if_inst.tx_accept_ok),
    .tx_overrun_flag(seg_bus_if_inst.tx_overrun_flag));
  // Free-running 200 MHz clock.
  always #2.5 mclk = ~mclk;
  task automatic check(input word_t seen, input word_t exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Offers one beat; a refused beat is held 20 cycles to prove it stays out.
  task automatic xfer(input int s, input logic f, l, b, input empty_t e,
                      input int k, input logic ok, input logic pop);
    word_t w;
    w = {16{k[7:0]}};
    @(posedge mclk);
    {reqSeg, reqFirst, reqLast, reqBad} <= {s[1:0], f, l, b};
    {reqEmpty, reqWord, reqChan, reqValid} <= {e, w, w[10:0], 1'b1};
    for (int n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (ok && seg_bus_if_inst.tx_accept_ok) break;
    end
    reqValid <= 1'b0;
    @(posedge mclk);
    check(reqTaken, ok);
    check(seg_bus_if_inst.tx_segment_valid[s], ok);
    // A taken beat opens the packet unless it closes it.
    if (ok) begin
      openExp = !l;
    end
    check(inPacket, openExp);
    if (pop) begin
      drainEn <= 1'b1;
      @(posedge mclk) drainEn <= 1'b0;
      @(posedge mclk);
      check(outValid, ok);
      if (ok) begin
        check(outSeg, s[1:0]);
        check(outBeat.word, w);
        check(outBeat.chan, w[10:0]);
        check({outBeat.first, outBeat.last}, {f, l});
        if (l) check({outBeat.bad, outBeat.empty},
                     {b, b ? {e[3], 3'h0} : e});
      end
    end
  endtask
  // Main sequence; reset released after 20 cycles.
  initial begin
    {mclk, rst, reqValid, reqFirst, reqLast, reqBad, drainEn} = 7'h20;
    {reqSeg, reqEmpty, reqChan, reqWord} = '0;
    openExp = 1'b0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    for (int s = 0; s < SEGS; s++) begin
      xfer(s, 1, 1, 0, 4'h5, s, 1, 1);
      xfer(s, 1, 0, 0, 4'h0, s + 8, 1, 1);
      xfer(s, 0, 1, s[0], 4'hf, s + 16, 1, 1);
    end
    xfer(0, 0, 1, 0, 4'h0, 40, 0, 1); // Non-first beat with no open packet.
    xfer(1, 1, 0, 0, 4'h0, 41, 1, 1);
    xfer(1, 1, 0, 0, 4'h0, 42, 0, 1); // Second opening inside a packet.
    // Fill past the ready threshold, then drain in order.
    for (int i = 0; i < 13; i++) xfer(2, 0, 0, 0, 4'h0, i, 1, 0);
    xfer(2, 0, 0, 0, 4'h0, 99, 0, 0); // Held off while not ready.
    repeat (3) @(posedge mclk);
    check(seg_bus_if_inst.tx_accept_ok, 1'b0);
    check(overrunSticky, 1'b0);
    for (int i = 0; i < 13; i++) begin
      @(posedge mclk) drainEn <= 1'b1;
      @(posedge mclk) drainEn <= 1'b0;
      @(posedge mclk);
      check(outBeat.word, {16{i[7:0]}});
    end
    repeat (3) @(posedge mclk);
    check(seg_bus_if_inst.tx_accept_ok, 1'b1);
    xfer(3, 0, 1, 1, 4'h7, 50, 1, 1);
    end_sim();
  end
  // Watchdog: the tests need well under 1000 cycles.
  initial begin
    #10000;
    miscompares++;
    end_sim();
  end
endmodule
`default_nettype wire
